// ---- design/hrt_pkg.sv ----
/*
 * Package for the hidden-access timekeeper: key, register indices, field
 * positions, reset values and timing counts.
 * Assumes a 40 MHz system clock and a 32.768 kHz tick input.
 */
package hrt_pkg;

	// -----------------------------------------------------------------
	// Key and transfer
	// -----------------------------------------------------------------
	localparam logic [63:0] KEY_PATTERN = 64'h5CA33AC55CA33AC5;
	localparam int          KEY_BITS    = 64;
	localparam int          XFER_BITS   = 64;

	// -----------------------------------------------------------------
	// Clock register indices
	// -----------------------------------------------------------------
	localparam logic [2:0] REG_HUND  = 3'h0;
	localparam logic [2:0] REG_SEC   = 3'h1;
	localparam logic [2:0] REG_MIN   = 3'h2;
	localparam logic [2:0] REG_HOUR  = 3'h3;
	localparam logic [2:0] REG_DAY   = 3'h4;
	localparam logic [2:0] REG_DATE  = 3'h5;
	localparam logic [2:0] REG_MONTH = 3'h6;
	localparam logic [2:0] REG_YEAR  = 3'h7;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int HOUR_12_BIT  = 7;
	localparam int HOUR_PM_BIT  = 5;
	localparam int DAY_RST_BIT  = 4;
	localparam int DAY_OSC_BIT  = 5;

	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [7:0] RST_HUND  = 8'h00;
	localparam logic [7:0] RST_SEC   = 8'h00;
	localparam logic [7:0] RST_MIN   = 8'h00;
	localparam logic [7:0] RST_HOUR  = 8'h00;
	localparam logic [7:0] RST_DAY   = 8'h01;
	localparam logic [7:0] RST_DATE  = 8'h01;
	localparam logic [7:0] RST_MONTH = 8'h01;
	localparam logic [7:0] RST_YEAR  = 8'h00;

	// -----------------------------------------------------------------
	// Timing: crystal ticks per hundredth (32768 / 100, fractional).
	// -----------------------------------------------------------------
	localparam int CRYSTAL_HZ   = 32768;
	localparam int HUND_PER_SEC = 100;

	// -----------------------------------------------------------------
	// Bus strobes, active low, and data bit, as sampled.
	// -----------------------------------------------------------------
	typedef struct packed {
		logic sel_n;
		logic oe_n;
		logic we_n;
		logic din;
	} hrt_bus_s;

	typedef enum logic [1:0] {
		ST_HUNT = 2'b00,
		ST_XFER = 2'b01,
		ST_DEAD = 2'b10
	} hrt_state_e;

endpackage

// ---- design/hrt_calendar.sv ----
/*
 * Calendar counter: advances eight BCD registers one hundredth at a time.
 * Assumes tick is a one-cycle enable, and load writes a whole register.
 */
`timescale 1ns/100ps
module hrt_calendar
(
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Hundredth tick and register load.
	input  wire logic             tick,
	input  wire logic             load,
	input  wire logic [2:0]       load_idx,
	input  wire logic [7:0]       load_val,
	// Register contents.
	output logic      [63:0]      regs
);

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	// BCD increment with wrap to a given low value past a given top.
	function automatic logic [7:0] bcd_inc(input logic [7:0] v,
		input logic [7:0] top, input logic [7:0] low);
		logic [7:0] r;
		r = v;
		if (v >= top)
			r = low;
		else if (v[3:0] == 4'h9)
			r = {v[7:4] + 4'h1, 4'h0};
		else
			r = v + 8'h01;
		return r;
	endfunction

	// Year is BCD 00..99; every fourth year leaps, 2000 and 2100 aside
	// only 2000 counts, so 2100 would need a century bit; 00 is leap.
	function automatic logic is_leap(input logic [7:0] y);
		logic [6:0] b;
		b = 7'(y[7:4]) * 7'h0A + 7'(y[3:0]);
		return b[1:0] == 2'b00;
	endfunction

	// -----------------------------------------------------------------
	// Decode of current fields
	// -----------------------------------------------------------------
	wire logic [7:0] hund  = regs[7:0];
	wire logic [7:0] sec   = regs[15:8];
	wire logic [7:0] mins  = regs[23:16];
	wire logic [7:0] hour  = regs[31:24];
	wire logic [7:0] day   = regs[39:32];
	wire logic [7:0] date  = regs[47:40];
	wire logic [7:0] month = regs[55:48];
	wire logic [7:0] year  = regs[63:56];
	wire logic       mode12 = hour[hrt_pkg::HOUR_12_BIT];
	wire logic       run    = ~day[hrt_pkg::DAY_OSC_BIT];
	localparam int HP = hrt_pkg::HOUR_PM_BIT;

	// Incremented fields, sliced where they are used.
	wire logic [7:0] inc12  = bcd_inc({3'h0, hour[4:0]}, 8'h12, 8'h01);
	wire logic [7:0] inc24  = bcd_inc({2'h0, hour[5:0]}, 8'h23, 8'h00);
	wire logic [7:0] inc_dy = bcd_inc({5'h0, day[2:0]}, 8'h07, 8'h01);

	// Month length in BCD, short months adjusted.
	logic [7:0] last_day;
	always_comb
	begin
		unique case (month[4:0])
			5'h02:   last_day = is_leap(year) ? 8'h29 : 8'h28;
			5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
			default: last_day = 8'h31;
		endcase
	end

	// Carries up the chain.
	wire logic c_sec  = tick & run & (hund == 8'h99);
	wire logic c_min  = c_sec & (sec[6:0] == 7'h59);
	wire logic c_hour = c_min & (mins[6:0] == 7'h59);
	wire logic end_12 = hour[4:0] == 5'h11 & hour[HP];
	wire logic c_day  = c_hour & (mode12 ? end_12 : hour[5:0] == 6'h23);
	wire logic c_mon  = c_day & (date[5:0] == last_day[5:0]);
	wire logic c_year = c_mon & (month[4:0] == 5'h12);

	// Next hour, 12- or 24-hour style.
	logic [7:0] next_hour;
	always_comb
	begin
		next_hour = hour;
		if (mode12)
		begin
			if (hour[4:0] == 5'h12)
				next_hour = {hour[7:5], 5'h01};
			else if (hour[4:0] == 5'h11)
				next_hour = {hour[7:6], ~hour[HP], 5'h12};
			else
				next_hour = {hour[7:5], inc12[4:0]};
		end
		else
			next_hour = {hour[7:6], inc24[5:0]};
	end

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	// Load wins over counting so a written register is kept whole.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			regs <= {hrt_pkg::RST_YEAR, hrt_pkg::RST_MONTH,
				hrt_pkg::RST_DATE, hrt_pkg::RST_DAY, hrt_pkg::RST_HOUR,
				hrt_pkg::RST_MIN, hrt_pkg::RST_SEC, hrt_pkg::RST_HUND};
		else if (load)
			regs[load_idx*8 +: 8] <= load_val;
		else if (tick & run)
		begin
			regs[7:0] <= bcd_inc(hund, 8'h99, 8'h00);
			if (c_sec)
				regs[15:8] <= bcd_inc(sec, 8'h59, 8'h00);
			if (c_min)
				regs[23:16] <= bcd_inc(mins, 8'h59, 8'h00);
			if (c_hour)
				regs[31:24] <= next_hour;
			if (c_day)
			begin
				regs[39:32] <= {day[7:3], inc_dy[2:0]};
				regs[47:40] <= c_mon ? 8'h01 : bcd_inc(date, 8'h31, 8'h01);
			end
			if (c_mon)
				regs[55:48] <= bcd_inc(month, 8'h12, 8'h01);
			if (c_year)
				regs[63:56] <= bcd_inc(year, 8'h99, 8'h00);
		end
	end

endmodule

// ---- design/hrt_top.sv ----
/*
 * Hidden-access timekeeper and memory select gate.
 * Assumes bus strobes and supply status arrive asynchronously from pins
 * and that crystal_pins is the 32.768 kHz oscillator as a level.
 */
`timescale 1ns/100ps
module hrt_top
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Host bus strobes, active low, and data bit.
	input  wire logic device_select_in_n,
	input  wire logic oe_n,
	input  wire logic we_n,
	input  wire logic din,
	input  wire logic xfer_reset_n,
	// Supply status and mode strap.
	input  wire logic main_supply_ok,
	input  wire logic rom_mode,
	input  wire logic crystal_pins,
	// Outputs.
	output logic      memory_select_out_n,
	output logic      dout,
	output logic      dout_oe
);

	// -----------------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------------
	// Two stages for every pin; stage one feeds stage two only.
	localparam int NS = 8;
	wire  logic [NS-1:0] pin_raw = {crystal_pins, rom_mode, main_supply_ok,
		xfer_reset_n, din, we_n, oe_n, device_select_in_n};
	logic [NS-1:0] sync1;
	logic [NS-1:0] sync2;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync1 <= 8'hFF;
			sync2 <= 8'hFF;
		end
		else
		begin
			sync1 <= pin_raw;
			sync2 <= sync1;
		end
	end

	hrt_pkg::hrt_bus_s bus;
	assign bus = '{sel_n: sync2[0], oe_n: sync2[1], we_n: sync2[2],
		din: sync2[3]};
	wire logic rst_pin_n = sync2[4];
	wire logic supply_ok = sync2[5];
	wire logic rom_sel   = sync2[6];
	wire logic xtal      = sync2[7];

	// -----------------------------------------------------------------
	// Cycle detection
	// -----------------------------------------------------------------
	// A cycle ends when select or its strobe rises; only selected
	// cycles count, so other addresses do nothing.
	logic prev_sel_n;
	logic prev_rd;
	logic prev_wr;
	wire  logic cur_rd  = ~bus.sel_n & ~bus.oe_n & bus.we_n;
	wire  logic cur_wr  = ~bus.sel_n & ~bus.we_n;
	wire  logic rd_end  = prev_rd & ~cur_rd;
	wire  logic wr_end  = prev_wr & ~cur_wr;
	wire  logic rd_start = cur_rd & ~prev_rd;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			prev_sel_n <= 1'b1;
			prev_rd    <= 1'b0;
			prev_wr    <= 1'b0;
		end
		else
		begin
			prev_sel_n <= bus.sel_n;
			prev_rd    <= cur_rd;
			prev_wr    <= cur_wr;
		end
	end

	// -----------------------------------------------------------------
	// Hundredth tick from crystal edges
	// -----------------------------------------------------------------
	// 32768 edges a second spread over 100 hundredths by an accumulator.
	logic        xtal_d;
	logic [16:0] acc;
	logic        tick;
	wire  logic  xtal_rise = xtal & ~xtal_d;
	wire  logic [16:0] acc_sum = acc + 17'(hrt_pkg::HUND_PER_SEC);
	wire  logic  acc_wrap = acc_sum >= 17'(hrt_pkg::CRYSTAL_HZ);
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			xtal_d <= 1'b1;
			acc    <= 17'h00000;
			tick   <= 1'b0;
		end
		else
		begin
			xtal_d <= xtal;
			tick   <= xtal_rise & acc_wrap;
			if (xtal_rise)
				acc <= acc_wrap ? acc_sum - 17'(hrt_pkg::CRYSTAL_HZ)
					: acc_sum;
		end
	end

	// -----------------------------------------------------------------
	// Access sequencer
	// -----------------------------------------------------------------
	hrt_pkg::hrt_state_e state;
	logic [6:0]  ptr;
	logic        miss;
	logic [63:0] shadow;
	logic [7:0]  wbyte;
	logic [63:0] regs;
	logic        load;
	wire  logic  key_bit  = hrt_pkg::KEY_PATTERN[ptr[5:0]];
	wire  logic  fail     = ~supply_ok;
	wire  logic  abort    = fail | (~rst_pin_n &
		~regs[4*8 + hrt_pkg::DAY_RST_BIT]);
	wire  logic  last_bit = ptr == 7'(hrt_pkg::XFER_BITS - 1);
	wire  logic  byte_end = ptr[2:0] == 3'h7;
	wire  logic  xfer_end = (state == hrt_pkg::ST_XFER) & (rd_end | wr_end);

	always_ff @(posedge clk)
	begin
		if (!rst_n | abort)
		begin
			state <= hrt_pkg::ST_DEAD;
			ptr   <= 7'h00;
			miss  <= 1'b1;
			wbyte <= 8'h00;
			load  <= 1'b0;
		end
		else
		begin
			load <= 1'b0;
			unique case (state)
				hrt_pkg::ST_DEAD, hrt_pkg::ST_HUNT:
				begin
					if (rd_end)
					begin
						state <= hrt_pkg::ST_HUNT;
						ptr   <= 7'h00;
						miss  <= 1'b0;
					end
					else if (wr_end & state == hrt_pkg::ST_HUNT & ~miss)
					begin
						if (bus.din != key_bit)
							miss <= 1'b1;
						else if (ptr == 7'(hrt_pkg::KEY_BITS - 1))
						begin
							state <= hrt_pkg::ST_XFER;
							ptr   <= 7'h00;
						end
						else
							ptr <= ptr + 7'h01;
					end
				end
				hrt_pkg::ST_XFER:
				begin
					if (xfer_end)
					begin
						if (wr_end)
							wbyte[ptr[2:0]] <= bus.din;
						load <= wr_end & byte_end;
						ptr  <= ptr + 7'h01;
						if (last_bit)
						begin
							state <= hrt_pkg::ST_DEAD;
							miss  <= 1'b1;
						end
					end
				end
				default:
					state <= hrt_pkg::ST_DEAD;
			endcase
		end
	end

	// Snapshot of the time at transfer start for a steady read.
	logic [2:0] load_idx;
	logic [7:0] load_byte;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			shadow    <= 64'h0000000000000000;
			load_idx  <= 3'h0;
			load_byte <= 8'h00;
		end
		else
		begin
			if (state != hrt_pkg::ST_XFER)
				shadow <= regs;
			if (xfer_end & wr_end & byte_end)
			begin
				load_idx  <= ptr[5:3];
				load_byte <= {bus.din, wbyte[6:0]};
			end
		end
	end

	// Writes during the key phase never reach the load path.
	// Loading is also cut while supply is failing.
	wire logic load_ok = load & supply_ok;

	hrt_calendar u_cal
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.tick     (tick),
		.load     (load_ok),
		.load_idx (load_idx),
		.load_val (load_byte),
		.regs     (regs)
	);

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	// Memory select: power fail forces the inverse of the strap level, transfer keeps
	// memory off, otherwise it follows device select.
	wire logic in_xfer = state == hrt_pkg::ST_XFER;
	wire logic next_mem_n = fail ? ~rom_sel : (in_xfer | bus.sel_n);
	wire logic next_oe    = in_xfer & cur_rd & ~fail;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			memory_select_out_n <= 1'b1;
			dout                <= 1'b0;
			dout_oe             <= 1'b0;
		end
		else
		begin
			memory_select_out_n <= next_mem_n;
			dout_oe <= next_oe;
			dout    <= shadow[ptr[5:0]];
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	a_xfer_mem_off: assert property (@(posedge clk) disable iff (!rst_n)
		in_xfer & ~fail |=> memory_select_out_n)
		else $error("Memory selected during transfer.");
	a_ram_fail_high: assert property (@(posedge clk) disable iff (!rst_n)
		fail & ~rom_sel |=> memory_select_out_n)
		else $error("RAM not protected on power fail.");
	a_rom_fail_low: assert property (@(posedge clk) disable iff (!rst_n)
		fail & rom_sel |=> !memory_select_out_n)
		else $error("ROM select not low on power fail.");
	a_pass_through: assert property (@(posedge clk) disable iff (!rst_n)
		supply_ok & ~in_xfer |=> memory_select_out_n == $past(bus.sel_n))
		else $error("Memory select not following.");
	a_read_resets: assert property (@(posedge clk) disable iff (!rst_n)
		rd_end & ~in_xfer & ~abort |=> ptr == 7'h00 && !miss)
		else $error("Read did not restart recognition.");
	a_miss_holds: assert property (@(posedge clk) disable iff (!rst_n)
		miss & ~rd_end & ~in_xfer |=> $stable(ptr))
		else $error("Pointer moved after mismatch.");
	a_no_key_load: assert property (@(posedge clk) disable iff (!rst_n)
		!in_xfer |=> !load)
		else $error("Load outside transfer.");
	a_fail_aborts: assert property (@(posedge clk) disable iff (!rst_n)
		fail |=> state == hrt_pkg::ST_DEAD && !load)
		else $error("Power fail did not abort.");
	a_unselected: assert property (@(posedge clk) disable iff (!rst_n)
		bus.sel_n & prev_sel_n & ~abort |=> $stable(ptr))
		else $error("Unselected cycle disturbed sequence.");
	a_relock: assert property (@(posedge clk) disable iff (!rst_n)
		xfer_end & last_bit & ~abort |=> state == hrt_pkg::ST_DEAD)
		else $error("No relock after transfer.");

	c_unlock: cover property (@(posedge clk) disable iff (!rst_n)
		state == hrt_pkg::ST_HUNT ##1 in_xfer);
	c_load: cover property (@(posedge clk) disable iff (!rst_n) load_ok);
	c_read_out: cover property (@(posedge clk) disable iff (!rst_n)
		dout_oe);
	c_fail: cover property (@(posedge clk) disable iff (!rst_n)
		in_xfer ##1 fail);

endmodule

// ---- test/hrt_mem_model.sv ----
/*
 * External memory model that sits behind the memory select output.
 * Assumes the select is active low and registered on the same clock.
 */
`timescale 1ns/100ps
module hrt_mem_model
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Select from the timekeeper.
	input  wire logic memory_select_out_n,
	// Number of accesses the memory has seen.
	output int        sel_cnt
);
	logic prev_n;

	// Counts each falling edge of the select as one memory access.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			prev_n  <= 1'b1;
			sel_cnt <= 0;
		end
		else
		begin
			prev_n <= memory_select_out_n;
			if (prev_n && !memory_select_out_n)
				sel_cnt <= sel_cnt + 1;
		end
	end
endmodule

// ---- test/hrt_top_tb.sv ----
/*
 * Self-checking bench for the hidden-access timekeeper.
 * Assumes the crystal input is held still, so the clock registers keep
 * whatever was last written.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("[ERR] %s exp %h got %h", nm, e, g); \
		end \
	end
module hrt_top_tb;
	localparam logic [63:0] KEY  = 64'h5CA33AC55CA33AC5;
	localparam logic [63:0] REGS = 64'h2406150313593742;
	logic clk = 1'b0;
	logic rst_n, sel_n, oe_n, we_n, din, supply_ok, rom_mode;
	logic mem_n, dout, dout_oe, oe_prev, got;
	logic exp_q[$];
	int   seed = 33090;
	int   error_cnt, checks_done, exp_sel, sel_cnt;

	// ---------------------------------------------------------------
	// Clock, design and memory
	// ---------------------------------------------------------------
	always #12.5 clk = ~clk;

	hrt_top dut (.clk(clk), .rst_n(rst_n), .device_select_in_n(sel_n),
		.oe_n(oe_n), .we_n(we_n), .din(din), .xfer_reset_n(1'b1),
		.main_supply_ok(supply_ok), .rom_mode(rom_mode),
		.crystal_pins(1'b0), .memory_select_out_n(mem_n), .dout(dout),
		.dout_oe(dout_oe));

	hrt_mem_model mem (.clk(clk), .rst_n(rst_n),
		.memory_select_out_n(mem_n), .sel_cnt(sel_cnt));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	// Prints the verdict and ends the run.
	task automatic finish_test();
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One selected cycle, then unselected noise on the strobes and data.
	task automatic cyc(input logic rd, input logic d, input logic pass);
		@(negedge clk);
		sel_n = 1'b0;
		oe_n  = ~rd;
		we_n  = rd;
		din   = d;
		repeat (5) @(negedge clk);
		`CHK("mem_sel", ~pass, mem_n)
		sel_n = 1'b1;
		oe_n  = 1'b1;
		we_n  = 1'b1;
		if (pass)
			exp_sel++;
		repeat (6) @(negedge clk)
		begin
			oe_n = $random(seed);
			we_n = $random(seed);
			din  = $random(seed);
		end
	endtask

	// Opening read, then the key with one bit flipped at bad (or none).
	task automatic unlock(input int bad);
		cyc(1'b1, 1'b0, 1'b1);
		for (int i = 0; i < 64; i++)
			cyc(1'b0, KEY[i] ^ (i == bad), 1'b1);
	endtask

	// Moves all 64 clock bits, noting each expected read bit.
	task automatic xfer(input logic rd, input logic [63:0] v);
		for (int i = 0; i < 64; i++)
		begin
			if (rd)
				exp_q.push_back(v[i]);
			cyc(rd, v[i], 1'b0);
		end
	endtask

	// ---------------------------------------------------------------
	// Output watcher: each rise of the drive enable answers one note.
	// ---------------------------------------------------------------
	always @(negedge clk)
	begin
		if (dout_oe === 1'b1 && oe_prev !== 1'b1)
		begin
			got = (exp_q.size() > 0) ? exp_q.pop_front() : ~dout;
			`CHK("dout", got, dout)
		end
		oe_prev = dout_oe;
	end

	// Cuts a hang short.
	initial
	begin
		#2500000;
		error_cnt++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		rst_n     = 1'b0;
		sel_n     = 1'b1;
		oe_n      = 1'b1;
		we_n      = 1'b1;
		din       = 1'b0;
		supply_ok = 1'b1;
		rom_mode  = 1'b0;
		repeat (20) @(negedge clk);
		`CHK("mem_rst", 1'b1, mem_n)
		`CHK("oe_rst", 1'b0, dout_oe)
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		// Locked cycles reach the memory.
		cyc(1'b1, 1'b0, 1'b1);
		cyc(1'b0, 1'b1, 1'b1);
		// Load the clock, then read it back after a fresh unlock.
		unlock(-1);
		xfer(1'b0, REGS);
		unlock(-1);
		xfer(1'b1, REGS);
		// A wrong bit locks out even a correct key that follows it.
		unlock(17);
		for (int i = 0; i < 64; i++)
			cyc(1'b0, KEY[i], 1'b1);
		cyc(1'b0, 1'b1, 1'b1);
		// A read in mid-key restarts the comparison.
		cyc(1'b1, 1'b0, 1'b1);
		for (int i = 0; i < 20; i++)
			cyc(1'b0, KEY[i], 1'b1);
		unlock(-1);
		xfer(1'b1, REGS);
		// Power fail mid-transfer in both memory kinds.
		for (int m = 0; m < 2; m++)
		begin
			rom_mode = m[0];
			unlock(-1);
			for (int i = 0; i < 4; i++)
				cyc(1'b0, ~REGS[i], 1'b0);
			supply_ok = 1'b0;
			repeat (6) @(negedge clk);
			`CHK("mem_fail", ~m[0], mem_n)
			if (m[0])
				exp_sel++;
			supply_ok = 1'b1;
			repeat (6) @(negedge clk);
			rom_mode = 1'b0;
			unlock(-1);
			xfer(1'b1, REGS);
		end
		repeat (20) @(negedge clk);
		`CHK("reads_left", 0, exp_q.size())
		`CHK("mem_count", exp_sel, sel_cnt)
		finish_test();
	end
endmodule
